// file: hw/sbrs_top.sv
`timescale 1ns/100ps
module sbrs_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    input wire logic select_n_pin,
    input wire logic shift_done,
    input wire logic [7:0] shift_rx_data,
    output logic shift_load,
    output logic [7:0] shift_tx_data,
    output logic shift_abort,
    output logic module_enable,
    output logic master_select,
    output logic bit_clk,
    output logic tx_irq,
    output logic rx_fault_irq
);
    import sbrs_pkg::*;

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] bit_rate;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic tx_full;
    logic shift_busy;
    logic receive_full_flag;
    logic mode_fault_flag;
    logic transmit_empty_flag;
    logic tx_armed;
    logic rx_armed;
    logic fault_armed;
    logic select_sync;
    logic enable_q;
    logic addr_valid;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] pend_addr;
    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic wr_bit_rate;
    logic wr_data;
    logic rd_status;
    logic rd_data;
    logic data_accept;
    logic load_now;
    logic fault_cond;
    logic rate_run;
    logic [7:0] status_view;
    logic [7:0] next_rdata;
    logic [7:0] next_ctrl_one;

    // ****************************************************************
    // Bus slave.
    // ****************************************************************

    // An address phase is taken when selected, ready and non-sequential.
    assign addr_valid = hsel && hready && (htrans == SBRS_HTRANS_NONSEQ);

    // Latch the address phase; reads get one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            pend_addr <= 8'h00;
        end else begin
            wr_pend <= addr_valid && hwrite;
            rd_pend <= addr_valid && !hwrite;
            if (addr_valid) begin
                pend_addr <= haddr[7:0];
            end
        end
    end

    // Ready drops for the first data-phase cycle of a read only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= SBRS_RESP_OKAY;
        end else begin
            hreadyout <= !(addr_valid && !hwrite);
            hresp <= SBRS_RESP_OKAY;
        end
    end

    // Decoded strobes act at the edge that ends the first data-phase cycle.
    assign wr_ctrl_one = wr_pend && (pend_addr == SBRS_OFF_CTRL_ONE);
    assign wr_ctrl_two = wr_pend && (pend_addr == SBRS_OFF_CTRL_TWO);
    assign wr_bit_rate = wr_pend && (pend_addr == SBRS_OFF_BIT_RATE);
    assign wr_data = wr_pend && (pend_addr == SBRS_OFF_DATA);
    assign rd_status = rd_pend && (pend_addr == SBRS_OFF_STATUS);
    assign rd_data = rd_pend && (pend_addr == SBRS_OFF_DATA);

    // Unused bits of the status view read as zero.
    always_comb begin
        status_view = 8'h00;
        status_view[SBRS_ST_RX_FULL] = receive_full_flag;
        status_view[SBRS_ST_TX_EMPTY] = transmit_empty_flag;
        status_view[SBRS_ST_MODE_FAULT] = mode_fault_flag;
    end

    // Read multiplexer; unmapped offsets answer zero.
    always_comb begin
        unique case (pend_addr)
            SBRS_OFF_CTRL_ONE: next_rdata = ctrl_one;
            SBRS_OFF_CTRL_TWO: next_rdata = ctrl_two;
            SBRS_OFF_BIT_RATE: next_rdata = bit_rate;
            SBRS_OFF_STATUS: next_rdata = status_view;
            SBRS_OFF_DATA: next_rdata = rx_buf;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is captured at the end of the wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            hrdata <= {24'h000000, next_rdata};
        end
    end

    // ****************************************************************
    // Control registers.
    // ****************************************************************

    // Only implemented bits of control one are stored.
    assign next_ctrl_one = hwdata[7:0] & SBRS_CTRL_ONE_MASK;

    // Control one: enables, master select and select output enable.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one <= SBRS_CTRL_ONE_RST & SBRS_CTRL_ONE_MASK;
        end else if (wr_ctrl_one) begin
            ctrl_one <= next_ctrl_one;
        end
    end

    // Control two holds the fault function enable.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_two <= SBRS_CTRL_TWO_RST;
        end else if (wr_ctrl_two) begin
            ctrl_two <= hwdata[7:0] & SBRS_CTRL_TWO_MASK;
        end
    end

    // The bit-rate register is writable whatever the transfer state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_rate <= SBRS_BIT_RATE_RST;
        end else if (wr_bit_rate) begin
            bit_rate <= hwdata[7:0] & SBRS_BIT_RATE_MASK;
        end
    end

    // Registered copies of enable and mode for the rest of the unit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_enable <= 1'b0;
            master_select <= 1'b0;
            enable_q <= 1'b0;
        end else begin
            module_enable <= ctrl_one[SBRS_C1_MODULE_EN];
            master_select <= ctrl_one[SBRS_C1_MASTER];
            enable_q <= ctrl_one[SBRS_C1_MODULE_EN];
        end
    end

    // ****************************************************************
    // Bit-rate generation.
    // ****************************************************************
    assign rate_run = ctrl_one[SBRS_C1_MODULE_EN] && ctrl_one[SBRS_C1_MASTER];

    sbrs_rate_gen u_rate_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(rate_run),
        .prescale_select(bit_rate[SBRS_BR_PRESCALE_LSB +: 3]),
        .rate_divider_select(bit_rate[SBRS_BR_DIVIDER_LSB +: 3]),
        .bit_clk(bit_clk)
    );

    // ****************************************************************
    // Transmit path.
    // ****************************************************************

    // A data write is taken only when armed by an earlier status read.
    assign data_accept = wr_data && tx_armed && ctrl_one[SBRS_C1_MODULE_EN];

    // Move the buffered byte when the shifter is free or just finished.
    assign load_now = tx_full && (!shift_busy || shift_done) && ctrl_one[SBRS_C1_MODULE_EN];

    // Arming for the transmit buffer: set by a status read seeing room.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_armed <= 1'b0;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            tx_armed <= 1'b0;
        end else if (rd_status && transmit_empty_flag) begin
            tx_armed <= 1'b1;
        end else if (wr_data) begin
            tx_armed <= 1'b0;
        end
    end

    // Transmit buffer; disabling the unit empties it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_full <= 1'b0;
            tx_buf <= 8'h00;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            tx_full <= 1'b0;
        end else if (data_accept) begin
            tx_full <= 1'b1;
            tx_buf <= hwdata[7:0];
        end else if (load_now) begin
            tx_full <= 1'b0;
        end
    end

    // The flag mirrors room in the buffer, changing at the same edge as the buffer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_empty_flag <= 1'b1;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            transmit_empty_flag <= 1'b1;
        end else if (data_accept) begin
            transmit_empty_flag <= 1'b0;
        end else begin
            transmit_empty_flag <= !tx_full || load_now;
        end
    end

    // Shifter handshake: load pulse, busy until completion.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_load <= 1'b0;
            shift_tx_data <= 8'h00;
            shift_busy <= 1'b0;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            shift_load <= 1'b0;
            shift_busy <= 1'b0;
        end else begin
            shift_load <= load_now;
            if (load_now) begin
                shift_tx_data <= tx_buf;
                shift_busy <= 1'b1;
            end else if (shift_done) begin
                shift_busy <= 1'b0;
            end
        end
    end

    // Abort pulse on the falling edge of the module enable.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_abort <= 1'b0;
        end else begin
            shift_abort <= enable_q && !ctrl_one[SBRS_C1_MODULE_EN];
        end
    end

    // ****************************************************************
    // Receive path.
    // ****************************************************************

    // Arming for the receive clear: status read seeing the flag set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_armed <= 1'b0;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            rx_armed <= 1'b0;
        end else if (rd_status && receive_full_flag) begin
            rx_armed <= 1'b1;
        end else if (rd_data) begin
            rx_armed <= 1'b0;
        end
    end

    // Receive flag; a completion in the clearing cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receive_full_flag <= 1'b0;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            receive_full_flag <= 1'b0;
        end else if (shift_done && shift_busy) begin
            receive_full_flag <= 1'b1;
        end else if (rd_data && rx_armed) begin
            receive_full_flag <= 1'b0;
        end
    end

    // Receive buffer; a new byte is lost while the old one is unread.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buf <= 8'h00;
        end else if (!ctrl_one[SBRS_C1_MODULE_EN]) begin
            rx_buf <= 8'h00;
        end else if (shift_done && shift_busy && (!receive_full_flag || (rd_data && rx_armed))) begin
            rx_buf <= shift_rx_data;
        end
    end

    // ****************************************************************
    // Mode fault.
    // ****************************************************************

    // The select pin is synchronised before any logic reads it.
    sbrs_sync #(
        .RESET_LEVEL(1'b1)
    ) u_select_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(select_n_pin),
        .sync_out(select_sync)
    );

    // Select low counts as a fault only in the fault-input configuration.
    assign fault_cond = ctrl_one[SBRS_C1_MODULE_EN] && ctrl_one[SBRS_C1_MASTER]
        && ctrl_two[SBRS_C2_FAULT_EN] && !ctrl_one[SBRS_C1_SEL_OUT_EN] && !select_sync;

    // Fault arming: a status read that sees the flag set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_armed <= 1'b0;
        end else if (rd_status && mode_fault_flag) begin
            fault_armed <= 1'b1;
        end else if (wr_ctrl_one) begin
            fault_armed <= 1'b0;
        end
    end

    // Fault flag; a fault present in the clearing cycle keeps it set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_fault_flag <= 1'b0;
        end else if (fault_cond) begin
            mode_fault_flag <= 1'b1;
        end else if (wr_ctrl_one && fault_armed) begin
            mode_fault_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt requests.
    // ****************************************************************

    // Requests are levels that follow the flags and their enables.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_irq <= 1'b0;
            rx_fault_irq <= 1'b0;
        end else begin
            tx_irq <= transmit_empty_flag && ctrl_one[SBRS_C1_TX_IE];
            rx_fault_irq <= ctrl_one[SBRS_C1_RX_FAULT_IE] && (receive_full_flag || mode_fault_flag);
        end
    end

endmodule : sbrs_top

// file: hw/sbrs_pkg.sv
package sbrs_pkg;

    // ****************************************************************
    // Register byte offsets.
    // ****************************************************************
    localparam logic [7:0] SBRS_OFF_CTRL_ONE = 8'h00;
    localparam logic [7:0] SBRS_OFF_CTRL_TWO = 8'h04;
    localparam logic [7:0] SBRS_OFF_BIT_RATE = 8'h08;
    localparam logic [7:0] SBRS_OFF_STATUS = 8'h0C;
    localparam logic [7:0] SBRS_OFF_DATA = 8'h10;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int SBRS_C1_RX_FAULT_IE = 7;
    localparam int SBRS_C1_MODULE_EN = 6;
    localparam int SBRS_C1_TX_IE = 5;
    localparam int SBRS_C1_MASTER = 4;
    localparam int SBRS_C1_SEL_OUT_EN = 1;
    localparam int SBRS_C2_FAULT_EN = 4;
    localparam int SBRS_BR_PRESCALE_LSB = 4;
    localparam int SBRS_BR_DIVIDER_LSB = 0;
    localparam int SBRS_ST_RX_FULL = 7;
    localparam int SBRS_ST_TX_EMPTY = 5;
    localparam int SBRS_ST_MODE_FAULT = 4;

    // ****************************************************************
    // Reset values and bus answers.
    // ****************************************************************
    localparam logic [7:0] SBRS_CTRL_ONE_RST = 8'h04;
    localparam logic [7:0] SBRS_CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] SBRS_BIT_RATE_RST = 8'h00;
    localparam logic [7:0] SBRS_CTRL_ONE_MASK = 8'hF2;
    localparam logic [7:0] SBRS_CTRL_TWO_MASK = 8'h10;
    localparam logic [7:0] SBRS_BIT_RATE_MASK = 8'h77;
    localparam logic [1:0] SBRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBRS_HTRANS_NONSEQ = 2'h2;

endpackage : sbrs_pkg

// file: hw/sbrs_sync.sv
`timescale 1ns/100ps
module sbrs_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    output logic sync_out
);

    logic stage_one;

    // Two flip-flops; only the second stage is read outside.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_one <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule : sbrs_sync

// file: hw/sbrs_rate_gen.sv
`timescale 1ns/100ps
module sbrs_rate_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [2:0] prescale_select,
    input wire logic [2:0] rate_divider_select,
    output logic bit_clk
);

    logic [2:0] pre_count;
    logic pre_tick;
    logic [6:0] div_count;
    logic [6:0] half_last;

    // Each bit clock level lasts 2**select prescaler ticks.
    assign half_last = 7'((8'h01 << rate_divider_select) - 8'h01);
    assign pre_tick = (pre_count == prescale_select);

    // Prescaler counts bus clocks, wrapping after select plus one of them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_count <= 3'h0;
        end else if (!run || pre_tick) begin
            pre_count <= 3'h0;
        end else begin
            pre_count <= pre_count + 3'h1;
        end
    end

    // Divider counts prescaler ticks and toggles the bit clock.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_count <= 7'h00;
            bit_clk <= 1'b0;
        end else if (!run) begin
            div_count <= 7'h00;
            bit_clk <= 1'b0;
        end else if (pre_tick) begin
            if (div_count >= half_last) begin
                div_count <= 7'h00;
                bit_clk <= ~bit_clk;
            end else begin
                div_count <= div_count + 7'h01;
            end
        end
    end

endmodule : sbrs_rate_gen

// file: tb/sbrs_top_properties.sv
`timescale 1ns/100ps
module sbrs_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic shift_load,
    input wire logic [7:0] shift_tx_data,
    input wire logic shift_abort,
    input wire logic module_enable,
    input wire logic master_select,
    input wire logic bit_clk
);
    import sbrs_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd;
    logic wr;
    // Bus requests taken at this edge.
    assign rd = hsel && hready && htrans == SBRS_HTRANS_NONSEQ && !hwrite;
    assign wr = hsel && hready && htrans == SBRS_HTRANS_NONSEQ && hwrite;
    resp_okay_a: assert property (hresp == SBRS_RESP_OKAY) else $error("bad response");
    read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read timing");
    write_nowait_a: assert property (wr |=> hreadyout) else $error("write stalled");
    load_pulse_a: assert property (shift_load |=> !shift_load) else $error("long load");
    tx_hold_a: assert property ($changed(shift_tx_data) |-> shift_load) else $error("byte moved");
    abort_seen_a: assert property ($fell(module_enable) |-> ##[0:2] shift_abort) else $error("no abort");
    abort_off_a: assert property (shift_abort |-> !module_enable) else $error("stray abort");
    off_noload_a: assert property (!module_enable [*2] |-> !shift_load) else $error("load when off");
    clk_quiet_a: assert property (!(module_enable && master_select) [*2] |-> !bit_clk) else $error("clock");
    read_c: cover property (rd);
    load_c: cover property (shift_load);
    abort_c: cover property ($fell(module_enable));
endmodule : sbrs_chk

bind sbrs_top sbrs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .shift_load(shift_load),
    .shift_tx_data(shift_tx_data), .shift_abort(shift_abort), .module_enable(module_enable),
    .master_select(master_select), .bit_clk(bit_clk));

// file: tb/sbrs_shifter_model.sv
`timescale 1ns/100ps
module sbrs_shifter_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic shift_load,
    input wire logic [7:0] shift_tx_data,
    input wire logic shift_abort,
    input wire logic [7:0] delay,
    output logic shift_done,
    output logic [7:0] shift_rx_data
);
    logic [7:0] cnt;
    logic [7:0] tx;
    // Runs one byte time per load and answers with the inverted byte.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 8'h00;
            tx <= 8'h00;
            shift_done <= 1'b0;
            shift_rx_data <= 8'h00;
        end else begin
            shift_done <= 1'b0;
            shift_rx_data <= ~shift_rx_data; // Junk outside the completion cycle.
            if (shift_abort) begin
                cnt <= 8'h00;
            end else if (shift_load) begin
                cnt <= delay;
                tx <= shift_tx_data;
            end else if (cnt == 8'h01) begin
                cnt <= 8'h00;
                shift_done <= 1'b1;
                shift_rx_data <= ~tx;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : sbrs_shifter_model

// file: tb/tb_spi_bit_rate_and_status_flags.sv
`timescale 1ns/100ps
module tb_spi_bit_rate_and_status_flags;
    import sbrs_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, select_n_pin = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, shift_done, shift_load, shift_abort;
    logic module_enable, master_select, bit_clk, tx_irq, rx_fault_irq;
    logic [7:0] shift_rx_data, shift_tx_data, b;
    logic [7:0] delay = 8'h1E;
    logic [7:0] rates[4] = '{8'h77, 8'h31, 8'h46, 8'h00};
    logic [15:0] mf[4] = '{16'h10D0, 16'h10D2, 16'h10C0, 16'h00D0};
    logic [15:0] e;
    logic [15:0] exp_rd[$];
    logic [7:0] exp_tx[$];
    logic rd_dp = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int n;
    time t0;

    assign hready = hreadyout;
    // Bus clock.
    always #5 hclk = ~hclk;

    sbrs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .select_n_pin(select_n_pin), .shift_done(shift_done),
        .shift_rx_data(shift_rx_data), .shift_load(shift_load), .shift_tx_data(shift_tx_data),
        .shift_abort(shift_abort), .module_enable(module_enable), .master_select(master_select),
        .bit_clk(bit_clk), .tx_irq(tx_irq), .rx_fault_irq(rx_fault_irq));
    sbrs_shifter_model u_shf (.hclk(hclk), .hresetn(hresetn), .shift_load(shift_load),
        .shift_tx_data(shift_tx_data), .shift_abort(shift_abort), .delay(delay),
        .shift_done(shift_done), .shift_rx_data(shift_rx_data));

    task automatic chk(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // One single word transfer; a read notes its masked expectation.
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [15:0] x);
        logic [31:0] r;
        r = $urandom();
        hsel <= 1'b1;
        haddr <= {r[31:8], a};
        htrans <= SBRS_HTRANS_NONSEQ;
        hwrite <= w;
        if (!w) begin
            exp_rd.push_back(x);
        end
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {r[23:0], d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 16'h0000);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        bus(a, 1'b0, 8'h00, {m, v});
    endtask : rd

    task automatic wait_irq();
        for (n = 0; n < 100 && rx_fault_irq !== 1'b1; n++) @(posedge hclk);
    endtask : wait_irq

    // Compares read data and loaded bytes with the oldest notes.
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            e = exp_rd.pop_front();
            chk((hrdata & {24'hFFFFFF, e[15:8]}) === {24'h000000, e[7:0]}, "read data");
        end
        rd_dp <= (hsel && hready && htrans == SBRS_HTRANS_NONSEQ && !hwrite) ? 1'b1 : (hreadyout ? 1'b0 : rd_dp);
        if (shift_load === 1'b1) begin
            chk(exp_tx.size() > 0 && shift_tx_data === exp_tx[0], "loaded byte");
            if (exp_tx.size() > 0) begin
                exp_tx.delete(0);
            end
        end
    end

    // Cuts a hung run short.
    initial begin
        #400000;
        failures++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h32E2A2E5));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        rd(8'h14, 8'hFF, 8'h00);
        wr(SBRS_OFF_STATUS, 8'hFF);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        repeat (6) begin
            b = $urandom();
            wr(SBRS_OFF_BIT_RATE, b);
            rd(SBRS_OFF_BIT_RATE, 8'hFF, b & SBRS_BIT_RATE_MASK);
        end
        // Bit clock period for extreme and middle codes.
        wr(SBRS_OFF_CTRL_ONE, 8'h50);
        foreach (rates[i]) begin
            wr(SBRS_OFF_BIT_RATE, rates[i]);
            repeat (2) @(posedge bit_clk);
            t0 = $time;
            @(posedge bit_clk);
            chk(($time - t0) / 10 == (rates[i][6:4] + 1) * (2 << rates[i][2:0]), "period");
        end
        // Queued transmit, ignored writes and the flag clear sequences.
        wr(SBRS_OFF_CTRL_ONE, 8'hF0);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        exp_tx.push_back(8'hA5);
        exp_tx.push_back(8'h3C);
        wr(SBRS_OFF_DATA, 8'hA5);
        wr(SBRS_OFF_DATA, 8'h11);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        wr(SBRS_OFF_DATA, 8'h3C);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h00);
        chk(tx_irq === 1'b0, "tx request");
        wr(SBRS_OFF_DATA, 8'h77);
        wait_irq();
        chk(rx_fault_irq === 1'b1, "rx request");
        rd(SBRS_OFF_STATUS, 8'hFF, 8'hA0);
        chk(tx_irq === 1'b1, "tx request");
        rd(SBRS_OFF_DATA, 8'hFF, 8'h5A);
        rd(SBRS_OFF_STATUS, 8'h80, 8'h00);
        wait_irq();
        rd(SBRS_OFF_DATA, 8'hFF, 8'hC3);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'hA0);
        rd(SBRS_OFF_DATA, 8'hFF, 8'hC3);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        chk(rx_fault_irq === 1'b0, "rx request");
        // Fault input only in the one qualifying configuration.
        foreach (mf[i]) begin
            wr(SBRS_OFF_CTRL_TWO, mf[i][15:8]);
            wr(SBRS_OFF_CTRL_ONE, mf[i][7:0]);
            rd(SBRS_OFF_CTRL_TWO, 8'hFF, mf[i][15:8]);
            rd(SBRS_OFF_CTRL_ONE, 8'hFF, mf[i][7:0]);
            select_n_pin <= 1'b0;
            repeat (6) @(posedge hclk);
            select_n_pin <= 1'b1;
            repeat (4) @(posedge hclk);
            wr(SBRS_OFF_CTRL_ONE, mf[i][7:0]);
            rd(SBRS_OFF_STATUS, 8'h10, {3'h0, i == 0, 4'h0});
            chk(rx_fault_irq === (i == 0), "fault request");
        end
        // Disable in mid-shift with a byte queued.
        wr(SBRS_OFF_CTRL_ONE, 8'h50);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        exp_tx.push_back(8'h81);
        wr(SBRS_OFF_DATA, 8'h81);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        wr(SBRS_OFF_DATA, 8'h42);
        wr(SBRS_OFF_CTRL_ONE, 8'h10);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        wr(SBRS_OFF_CTRL_ONE, 8'h50);
        repeat (60) @(posedge hclk);
        rd(SBRS_OFF_STATUS, 8'hFF, 8'h20);
        chk(exp_tx.size() == 0, "bytes left");
        @(posedge hclk);
        chk(exp_rd.size() == 0, "reads left");
        end_of_test();
    end
endmodule : tb_spi_bit_rate_and_status_flags
